// file: src/sfrie_bank.sv
// System interrupt enable and flag register bank with APB access
`timescale 1ns/10ps

module sfrie_bank (
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Instruction fetch observation
  input  wire logic        fetchValid,
  input  wire logic [15:0] fetchAddr,
  // System reset sources and events
  input  wire logic        pucRequest,
  input  wire logic        extResetEvent,
  input  wire logic        wdogOverflow,
  input  wire logic        keyViolation,
  input  wire logic        wdogIntervalMode,
  input  wire logic        oscFaultEvent,
  input  wire logic        pinNmiEvent,
  input  wire logic        accessViolation,
  // Reset outputs
  output logic             fetchResetReq,
  output logic             powerUpClear,
  // Enable bits toward the modules
  output logic             wdogIntervalIrqEn,
  output logic             oscFaultIrqEn,
  output logic             pinNmiIrqEn,
  output logic             flashAccessViolationIrqEn,
  // Requests toward the processor
  output logic             wdogIrq,
  output logic             nmiRequest,
  output logic             irq
);

  // ==========================================================
  // Declarations
  logic [7:0]  enableA_reg;
  logic [7:0]  enableA_next;
  logic [7:0]  flagA_reg;
  logic [7:0]  flagA_next;
  logic [7:0]  evtStat_reg;
  logic [7:0]  evtStat_next;
  logic [7:0]  evtMask_reg;
  logic [7:0]  evtMask_next;
  logic        accvPrev_reg;
  logic        pucSeen_reg;
  logic [31:0] prdata_next;
  logic        power_up_clear;
  logic        wrEn;
  logic        rdSetup;
  logic [5:0]  regIdx;
  logic        mapped;
  logic [7:0]  wByte;
  logic [7:0]  flagSet;
  logic [7:0]  evtSet;
  logic        accvRise;

  // ==========================================================
  // Clear what software clears, then add what hardware sets
  function automatic logic [7:0] applyW1c(
    input logic [7:0] cur,
    input logic [7:0] clr,
    input logic [7:0] set
  );
    return (cur & ~clr) | set;
  endfunction : applyW1c

  // ==========================================================
  // Fetch guard
  sfrie_fetch_guard u_guard (
    .clk           (clk),
    .rst           (rst),
    .fetchValid    (fetchValid),
    .fetchAddr     (fetchAddr),
    .fetchResetReq (fetchResetReq)
  );

  // Power-up clear from PUC request, fetch reset or external reset; power-on acts through rst
  assign power_up_clear = pucRequest || fetchResetReq || extResetEvent;

  // ==========================================================
  // APB decode
  // Byte address is the register index times four
  assign regIdx  = paddr[7:2];
  assign mapped  = (paddr[1:0] == 2'h0) && (regIdx <= sfrie_pkg::IDX_EVT_MASK);
  assign wrEn    = psel && penable && pwrite && mapped && pstrb[0];
  assign rdSetup = psel && !penable;
  assign wByte   = pwdata[7:0];
  // Zero wait states; misaligned or unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data captured in the setup cycle, presented in the access cycle
  always_comb begin
    prdata_next = prdata;
    if (rdSetup) begin
      prdata_next = 32'h0000_0000;
      case (regIdx)
        sfrie_pkg::IDX_ENABLE_A: begin
          prdata_next[7:0] = enableA_reg & sfrie_pkg::ENABLE_A_IMPL;
        end
        sfrie_pkg::IDX_ENABLE_B: begin
          prdata_next[7:0] = 8'h00;
        end
        sfrie_pkg::IDX_FLAG_A: begin
          prdata_next[7:0] = flagA_reg & sfrie_pkg::FLAG_A_IMPL;
        end
        sfrie_pkg::IDX_FLAG_B: begin
          prdata_next[7:0] = 8'h00;
        end
        sfrie_pkg::IDX_EVT_STAT: begin
          prdata_next[7:0] = evtStat_reg;
        end
        sfrie_pkg::IDX_EVT_MASK: begin
          prdata_next[7:0] = evtMask_reg;
        end
        default: begin
          prdata_next = 32'h0000_0000;
        end
      endcase
      if (paddr[1:0] != 2'h0) begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_next;
    end
  end

  // ==========================================================
  // Enable register A
  // Writes to the second enable register land nowhere
  always_comb begin
    enableA_next = enableA_reg;
    if (wrEn && regIdx == sfrie_pkg::IDX_ENABLE_A) begin
      enableA_next = wByte & sfrie_pkg::ENABLE_A_IMPL;
    end
    if (power_up_clear) begin
      enableA_next = sfrie_pkg::ENABLE_A_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enableA_reg <= sfrie_pkg::ENABLE_A_RESET;
    end else begin
      enableA_reg <= enableA_next;
    end
  end

  assign wdogIntervalIrqEn         = enableA_reg[sfrie_pkg::EN_WDOG];
  assign oscFaultIrqEn             = enableA_reg[sfrie_pkg::EN_OSC];
  assign pinNmiIrqEn               = enableA_reg[sfrie_pkg::EN_NMI];
  assign flashAccessViolationIrqEn = enableA_reg[sfrie_pkg::EN_ACCV];

  // ==========================================================
  // Flag register A
  // Hardware sets win over a software write in the same cycle
  always_comb begin
    flagSet = 8'h00;
    flagSet[sfrie_pkg::FL_WDOG] = wdogOverflow || keyViolation;
    flagSet[sfrie_pkg::FL_OSC]  = oscFaultEvent;
    flagSet[sfrie_pkg::FL_EXT]  = extResetEvent;
    flagSet[sfrie_pkg::FL_NMI]  = pinNmiEvent;
    flagA_next = flagA_reg;
    if (wrEn && regIdx == sfrie_pkg::IDX_FLAG_A) begin
      flagA_next = applyW1c(flagA_reg, ~wByte, wByte) & sfrie_pkg::FLAG_A_IMPL;
    end
    flagA_next = flagA_next | flagSet;
    if (power_up_clear) begin
      // Power-up clear sets the oscillator flag and drops the pin flag unless pinNmiEvent is high in the same cycle
      flagA_next[sfrie_pkg::FL_OSC] = 1'b1;
      flagA_next[sfrie_pkg::FL_NMI] = pinNmiEvent;
    end
    if (extResetEvent) begin
      flagA_next[sfrie_pkg::FL_WDOG] = 1'b0;
    end
  end

  // Power-on reset sets the oscillator and power-on flags and clears the rest
  always_ff @(posedge clk) begin
    if (rst) begin
      flagA_reg <= sfrie_pkg::FLAG_A_RESET;
    end else begin
      flagA_reg <= flagA_next;
    end
  end

  // ==========================================================
  // Request outputs
  // No global enable enters here, so it cannot block these sources
  assign nmiRequest = (flagA_reg[sfrie_pkg::FL_NMI] && pinNmiIrqEn)
                   || (flagA_reg[sfrie_pkg::FL_OSC] && oscFaultIrqEn)
                   || (accessViolation && flashAccessViolationIrqEn);
  // In reset mode the watchdog resets the chip; the enable is moot
  assign wdogIrq = wdogIntervalMode && wdogIntervalIrqEn
                && flagA_reg[sfrie_pkg::FL_WDOG];
  // Module-local flags such as timer or port flags are not mirrored here
  assign powerUpClear = pucSeen_reg;

  // ==========================================================
  // Event status and mask
  assign accvRise = accessViolation && !accvPrev_reg;

  always_comb begin
    evtSet = 8'h00;
    evtSet[sfrie_pkg::EV_WDOG]  = flagSet[sfrie_pkg::FL_WDOG];
    evtSet[sfrie_pkg::EV_OSC]   = oscFaultEvent;
    evtSet[sfrie_pkg::EV_NMI]   = pinNmiEvent;
    evtSet[sfrie_pkg::EV_ACCV]  = accvRise;
    evtSet[sfrie_pkg::EV_FETCH] = fetchResetReq;
    evtStat_next = evtStat_reg | evtSet;
    evtMask_next = evtMask_reg;
    if (wrEn && regIdx == sfrie_pkg::IDX_EVT_STAT) begin
      evtStat_next = applyW1c(evtStat_reg, wByte, evtSet) & sfrie_pkg::EVT_IMPL;
    end
    if (wrEn && regIdx == sfrie_pkg::IDX_EVT_MASK) begin
      evtMask_next = wByte & sfrie_pkg::EVT_IMPL;
    end
  end

  // Status survives power-up clear so software can see the cause
  always_ff @(posedge clk) begin
    if (rst) begin
      evtStat_reg  <= sfrie_pkg::EVT_RESET;
      evtMask_reg  <= sfrie_pkg::EVT_RESET;
      accvPrev_reg <= 1'b0;
      pucSeen_reg  <= 1'b1;
    end else begin
      evtStat_reg  <= evtStat_next;
      evtMask_reg  <= evtMask_next;
      accvPrev_reg <= accessViolation;
      pucSeen_reg  <= power_up_clear;
    end
  end

  // Level interrupt while any unmasked status bit stands
  assign irq = |(evtStat_reg & evtMask_reg);

endmodule : sfrie_bank

// file: shared/sfrie_pkg.sv
// Constants shared by the system interrupt enable and flag register bank
package sfrie_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_ENABLE_A = 6'h00;
  localparam logic [5:0] IDX_ENABLE_B = 6'h01;
  localparam logic [5:0] IDX_FLAG_A   = 6'h02;
  localparam logic [5:0] IDX_FLAG_B   = 6'h03;
  localparam logic [5:0] IDX_EVT_STAT = 6'h04;
  localparam logic [5:0] IDX_EVT_MASK = 6'h05;

  // ==========================================================
  // Enable register A field positions
  localparam int EN_WDOG  = 0;
  localparam int EN_OSC   = 1;
  localparam int EN_NMI   = 4;
  localparam int EN_ACCV  = 5;
  localparam logic [7:0] ENABLE_A_IMPL  = 8'h33;
  localparam logic [7:0] ENABLE_A_RESET = 8'h00;

  // ==========================================================
  // Flag register A field positions
  localparam int FL_WDOG  = 0;
  localparam int FL_OSC   = 1;
  localparam int FL_POR   = 2;
  localparam int FL_EXT   = 3;
  localparam int FL_NMI   = 4;
  localparam logic [7:0] FLAG_A_IMPL  = 8'h1f;
  localparam logic [7:0] FLAG_A_RESET = 8'h06;

  // ==========================================================
  // Event status and mask layout
  localparam int EV_WDOG  = 0;
  localparam int EV_OSC   = 1;
  localparam int EV_NMI   = 2;
  localparam int EV_ACCV  = 3;
  localparam int EV_FETCH = 4;
  localparam logic [7:0] EVT_IMPL  = 8'h1f;
  localparam logic [7:0] EVT_RESET = 8'h00;

  // ==========================================================
  // Fetch address map
  localparam logic [15:0] PERIPH_TOP = 16'h01ff;
  localparam logic [15:0] RAM_LO     = 16'h0200;
  localparam logic [15:0] RAM_HI     = 16'h027f;
  localparam logic [15:0] INFO_LO    = 16'h1000;
  localparam logic [15:0] INFO_HI    = 16'h10ff;
  localparam logic [15:0] MAIN_LO    = 16'hf800;
  localparam logic [15:0] MAIN_HI    = 16'hffff;

endpackage : sfrie_pkg

// file: src/sfrie_fetch_guard.sv
// Illegal instruction fetch detector raising a one-cycle reset request
`timescale 1ns/10ps

module sfrie_fetch_guard (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Fetch observation
  input  wire logic        fetchValid,
  input  wire logic [15:0] fetchAddr,
  // Reset request
  output logic             fetchResetReq
);

  logic fetchResetReq_next;

  // ==========================================================
  // Address classification
  // Lowest vector slots sit inside main flash, so they fetch as code
  function automatic logic isIllegal(input logic [15:0] a);
    logic ok;
    ok = 1'b0;
    if (a >= sfrie_pkg::RAM_LO && a <= sfrie_pkg::RAM_HI) begin
      ok = 1'b1;
    end
    if (a >= sfrie_pkg::INFO_LO && a <= sfrie_pkg::INFO_HI) begin
      ok = 1'b1;
    end
    if (a >= sfrie_pkg::MAIN_LO && a <= sfrie_pkg::MAIN_HI) begin
      ok = 1'b1;
    end
    if (a <= sfrie_pkg::PERIPH_TOP) begin
      ok = 1'b0;
    end
    return !ok;
  endfunction : isIllegal

  // ==========================================================
  // Request generation
  always_comb begin
    fetchResetReq_next = fetchValid && isIllegal(fetchAddr);
  end

  // Registered so the reset request is glitch free
  always_ff @(posedge clk) begin
    if (rst) begin
      fetchResetReq <= 1'b0;
    end else begin
      fetchResetReq <= fetchResetReq_next;
    end
  end

endmodule : sfrie_fetch_guard

// file: verification/sfrie_bank_assertions.sv
// Port-level checks on the system interrupt enable and flag register bank
`timescale 1ns/10ps

module sfrie_bank_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Fetch and sources
  input wire logic        fetchValid,
  input wire logic [15:0] fetchAddr,
  input wire logic        pucRequest,
  input wire logic        wdogIntervalMode,
  input wire logic        accessViolation,
  // Outputs watched
  input wire logic        fetchResetReq,
  input wire logic        powerUpClear,
  input wire logic        wdogIntervalIrqEn,
  input wire logic        oscFaultIrqEn,
  input wire logic        pinNmiIrqEn,
  input wire logic        flashAccessViolationIrqEn,
  input wire logic        wdogIrq,
  input wire logic        nmiRequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Fetch guard steps: illegal fetch, pulse, then power-up clear with the watchdog enable low
  sequence s_lowFetch;
    fetchValid && fetchAddr <= 16'h01ff;
  endsequence
  sequence s_resetPulse;
    fetchResetReq ##1 (powerUpClear && !wdogIntervalIrqEn);
  endsequence

  a_low_fetch_reset: assert property (s_lowFetch |=> s_resetPulse)
    else $error("peripheral range fetch gave no reset");
  a_vector_fetch_ok: assert property (
    fetchValid && fetchAddr >= 16'hffc0 && fetchAddr <= 16'hffdf |=> !fetchResetReq)
    else $error("unused vector slot fetch gave reset");

  // ==========================================================
  // Request gating: own enables only, no global enable exists
  a_nmi_all_off: assert property (
    !(pinNmiIrqEn || oscFaultIrqEn || flashAccessViolationIrqEn) |-> !nmiRequest)
    else $error("nmi request with all enables low");
  a_accv_nmi_on: assert property (
    accessViolation && flashAccessViolationIrqEn |-> nmiRequest)
    else $error("access violation not forwarded");
  a_wdog_mode_gate: assert property (
    wdogIrq |-> wdogIntervalMode && wdogIntervalIrqEn)
    else $error("watchdog irq outside interval mode");
  a_puc_clears_en: assert property (pucRequest |=> powerUpClear &&
    !(wdogIntervalIrqEn || oscFaultIrqEn || pinNmiIrqEn || flashAccessViolationIrqEn))
    else $error("power-up clear left an enable set");

  // ==========================================================
  // Read data: missing bits read zero; zero wait states and an error on misaligned or unmapped access
  a_upper_bits_zero: assert property (
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_empty_regs_zero: assert property (
    psel && penable && !pwrite && (paddr == 8'h04 || paddr == 8'h0c) |-> prdata == 32'h0)
    else $error("empty register read nonzero");
  a_enable_a_holes: assert property (
    psel && penable && !pwrite && paddr == 8'h00 |-> (prdata[7:0] & 8'hcc) == 8'h0)
    else $error("enable register hole bit set");
  a_zero_wait_err: assert property (psel && penable |-> pready &&
    pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00))
    else $error("ready or error response wrong");
endmodule : sfrie_bank_assertions

bind sfrie_bank sfrie_bank_assertions sfrie_bank_assertions_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetchValid(fetchValid),
  .fetchAddr(fetchAddr), .pucRequest(pucRequest), .wdogIntervalMode(wdogIntervalMode),
  .accessViolation(accessViolation), .fetchResetReq(fetchResetReq),
  .powerUpClear(powerUpClear), .wdogIntervalIrqEn(wdogIntervalIrqEn),
  .oscFaultIrqEn(oscFaultIrqEn), .pinNmiIrqEn(pinNmiIrqEn),
  .flashAccessViolationIrqEn(flashAccessViolationIrqEn), .wdogIrq(wdogIrq),
  .nmiRequest(nmiRequest));

// file: verification/sfrie_bank_test.sv
// Self-checking bench for the system interrupt enable and flag register bank
`timescale 1ns/10ps

module sfrie_bank_test;
  // ==========================================================
  // Signals; ev bits: overflow, key, osc, nmi pin, ext reset, puc
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, errv, fetchValid;
  logic        wdogIntervalMode, accessViolation, fetchResetReq, powerUpClear, irq;
  logic        wdogIntervalIrqEn, oscFaultIrqEn, pinNmiIrqEn, flaEn, wdogIrq, nmiRequest;
  logic [7:0]  paddr, rv;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic [5:0]  ev;
  logic [15:0] fetchAddr;
  logic [15:0] fa[8] = '{16'h0000, 16'h01ff, 16'h0200, 16'h0280, 16'h1000, 16'hffc0,
                         16'hffde, 16'hf7ff};
  logic [31:0] rstVal[6] = '{32'h0, 32'h0, 32'h06, 32'h0, 32'h0, 32'h0};
  int          badCount = 0;
  int          checked = 0;
  int          seed = 10608;

  sfrie_bank sfrie_bank_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
    .pucRequest(ev[5]), .extResetEvent(ev[4]), .wdogOverflow(ev[0]), .keyViolation(ev[1]),
    .wdogIntervalMode(wdogIntervalMode), .oscFaultEvent(ev[2]), .pinNmiEvent(ev[3]),
    .accessViolation(accessViolation), .fetchResetReq(fetchResetReq),
    .powerUpClear(powerUpClear), .wdogIntervalIrqEn(wdogIntervalIrqEn),
    .oscFaultIrqEn(oscFaultIrqEn), .pinNmiIrqEn(pinNmiIrqEn),
    .flashAccessViolationIrqEn(flaEn), .wdogIrq(wdogIrq), .nmiRequest(nmiRequest),
    .irq(irq));

  // ==========================================================
  // Clock and hang guard; the tests need well under 2000 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    tallyAndFinish();
  end

  // ==========================================================
  // Helpers
  function automatic logic badFetch(input logic [15:0] a);
    return !((a >= 16'h0200 && a <= 16'h027f) || (a >= 16'h1000 && a <= 16'h10ff) ||
             a >= 16'hf800);
  endfunction : badFetch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Setup, access until pready, then release; #1 lets the edge's updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog process ends a wait that never sees ready
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdv);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
    #1;
  endtask : pulse
  task automatic fetch(input logic [15:0] a);
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchAddr  <= a;
    @(posedge clk);
    fetchValid <= 1'b0;
    #1 chk("fetch reset", badFetch(a), fetchResetReq);
  endtask : fetch
  task automatic doReset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask : doReset
  task automatic tallyAndFinish();
    $display("Comparisons %0d, mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tallyAndFinish

  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fetchValid, fetchAddr, ev} = '0;
    {wdogIntervalMode, accessViolation} = 2'b00;
    pstrb = 4'h1;
    rst = 1'b1;
    doReset();
    foreach (rstVal[i]) rd(8'(4 * i), rstVal[i], "reset value");
    repeat (8) begin
      rv = 8'($random(seed));
      apb(1'b1, 8'h00, {24'hffffff, rv});
      rd(8'h00, {24'h0, rv & 8'h33}, "enable A");
      chk("enable ports", {rv[5:4], rv[1:0]}, {flaEn, pinNmiIrqEn, oscFaultIrqEn,
          wdogIntervalIrqEn});
    end
    apb(1'b1, 8'h04, 32'hff);
    rd(8'h04, 32'h0, "enable B");
    apb(1'b1, 8'h08, 32'hff);
    rd(8'h08, 32'h1f, "flag A");
    apb(1'b1, 8'h08, 32'h0);
    pulse(0);
    rd(8'h08, 32'h01, "overflow flag");
    apb(1'b1, 8'h08, 32'h0);
    pulse(1);
    rd(8'h08, 32'h01, "key flag");
    apb(1'b1, 8'h00, 32'h33);
    pulse(4);
    rd(8'h08, 32'h0a, "pin reset flags");
    rd(8'h00, 32'h0, "pin reset enables");
    apb(1'b1, 8'h00, 32'h33);
    apb(1'b1, 8'h08, 32'h0);
    pulse(5);
    rd(8'h00, 32'h0, "puc enables");
    rd(8'h08, 32'h02, "puc flags");
    // Watchdog request only in interval mode
    apb(1'b1, 8'h00, 32'h01);
    pulse(0);
    @(posedge clk) wdogIntervalMode <= 1'b1;
    #1 chk("interval irq", 1, wdogIrq);
    @(posedge clk) wdogIntervalMode <= 1'b0;
    #1 chk("watchdog mode irq", 0, wdogIrq);
    // Pin and access requests follow their own enables
    apb(1'b1, 8'h00, 32'h10);
    pulse(3);
    chk("pin nmi on", 1, nmiRequest);
    apb(1'b1, 8'h00, 32'h0);
    chk("pin nmi off", 0, nmiRequest);
    @(posedge clk) accessViolation <= 1'b1;
    apb(1'b1, 8'h00, 32'h20);
    chk("access nmi", 1, nmiRequest);
    @(posedge clk) accessViolation <= 1'b0;
    // Status, mask and level interrupt
    apb(1'b1, 8'h10, 32'h1f);
    apb(1'b1, 8'h14, 32'h1f);
    pulse(2);
    rd(8'h10, 32'h02, "status");
    chk("irq set", 1, irq);
    apb(1'b1, 8'h14, 32'h0);
    chk("irq masked", 0, irq);
    apb(1'b1, 8'h10, 32'h02);
    rd(8'h10, 32'h0, "status cleared");
    rd(8'h18, 32'h0, "unmapped read");
    chk("unmapped error", 1, errv);
    foreach (fa[i]) fetch(fa[i]);
    rd(8'h10, 32'h10, "fetch status");
    repeat (8) fetch(16'($random(seed)));
    // Power-on again restores the flag defaults
    apb(1'b1, 8'h08, 32'h19);
    doReset();
    rd(8'h08, 32'h06, "power-on flags");
    tallyAndFinish();
  end
endmodule : sfrie_bank_test
